/* File: verilog/ssf_pkg.sv */
/*
 * Package for the supply status and fault flag block: register map,
 * field positions, reset values and code formats.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
package ssf_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int AW = 6;
   localparam logic [5:0] OFS_DSUP     = 6'h00;
   localparam logic [5:0] OFS_ASUP     = 6'h04;
   localparam logic [5:0] OFS_RREF     = 6'h08;
   localparam logic [5:0] OFS_MISMATCH = 6'h0C;
   localparam logic [5:0] OFS_FLAGS    = 6'h10;
   localparam logic [5:0] OFS_CMD      = 6'h14;
   localparam logic [5:0] OFS_THR      = 6'h18;
   localparam logic [5:0] OFS_IRQ_ST   = 6'h1C;
   localparam logic [5:0] OFS_IRQ_MASK = 6'h20;

   // ----------------------------------------------------------------
   // Code formats
   // ----------------------------------------------------------------
   localparam real RESULT_LSB_V = 0.00015;
   localparam real THR_LSB_V    = 0.0024;
   localparam real OFFSET_V     = 1.5;
   localparam int  RES_W        = 16;
   localparam int  THR_W        = 12;
   localparam int  THR_SHIFT    = 4;
   localparam logic [15:0] RD_RESET       = 16'h7FFF;
   localparam logic [15:0] RD_CLEAR       = 16'h8000;
   localparam logic [15:0] MISMATCH_RESET = 16'hFFFF;
   localparam logic [11:0] UV_RESET       = 12'h800;
   localparam logic [11:0] OV_RESET       = 12'h7FF;
   localparam int  THR_UV_LSB = 0;
   localparam int  THR_OV_LSB = 16;

   // ----------------------------------------------------------------
   // Fault flags and clear selectors
   // ----------------------------------------------------------------
   localparam int NFLAG    = 5;
   localparam int F_AOV    = 0;
   localparam int F_AUV    = 1;
   localparam int F_DOV    = 2;
   localparam int F_DUV    = 3;
   localparam int F_TRIM   = 4;
   localparam int NSEL     = 6;
   localparam int SEL_MISM = 5;
   localparam logic [4:0] FLAG_RESET = 5'h1F;

   // ----------------------------------------------------------------
   // Command register and interrupt status
   // ----------------------------------------------------------------
   localparam int CMD_CLR_AUX  = 0;
   localparam int CMD_FLAG_CLR = 1;
   localparam int CMD_SEL_LSB  = 8;
   localparam int NIRQ     = 4;
   localparam int IRQ_MISM = 0;
   localparam int IRQ_RAIL = 1;
   localparam int IRQ_TRIM = 2;
   localparam int IRQ_AUXC = 3;
   localparam logic [3:0] IRQ_ST_RESET   = 4'h0;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

   // Threshold code widened to the 16-bit result scale, sign kept
   function automatic logic [15:0] thr_to_code(input logic [11:0] thr);
      thr_to_code = {thr, 4'h0};
   endfunction : thr_to_code

endpackage : ssf_pkg

/* File: verilog/ssf_sticky.sv */
/*
 * Sticky flag bank: set wins over clear, constant reset value.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/10ps
module ssf_sticky #(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   // Flag control
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // An event in the clearing cycle survives the clear
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= RST;
      end else begin
         q <= (q & ~clr) | set;
      end
   end

endmodule : ssf_sticky

/* File: verilog/ssf_reading.sv */
/*
 * One 16-bit supply reading register.
 * Assumes load, sleep and clear strobes are one-cycle pulses on ref_clk.
 */
`timescale 1ns/10ps
module ssf_reading (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Update sources
   input  wire logic        load,
   input  wire logic [15:0] data,
   input  wire logic        sleep_enter,
   input  wire logic        clear_aux,
   output logic      [15:0] q
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Sleep wins: the converter is off, so a stale clear must not linger
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= ssf_pkg::RD_RESET;
      end else if (sleep_enter) begin
         q <= ssf_pkg::RD_RESET;
      end else if (clear_aux) begin
         q <= ssf_pkg::RD_CLEAR;
      end else if (load) begin
         q <= data;
      end
   end

endmodule : ssf_reading

/* File: verilog/ssf_status.sv */
/*
 * Supply status readback and fault flag bank with Avalon-MM slave.
 * Assumes converter, power manager and command decoder on ref_clk.
 */
`timescale 1ns/10ps
module ssf_status (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   // Converter results
   input  wire logic        dsup_load,
   input  wire logic [15:0] dsup_data,
   input  wire logic        asup_load,
   input  wire logic [15:0] asup_data,
   input  wire logic        rref_load,
   input  wire logic [15:0] rref_data,
   // Fault events
   input  wire logic [15:0] mismatch_evt,
   input  wire logic        analog_over_evt,
   input  wire logic        analog_under_evt,
   input  wire logic        digital_over_evt,
   input  wire logic        digital_under_evt,
   input  wire logic        trim_err_evt,
   // Power state
   input  wire logic        sleep_enter,
   input  wire logic        sleep_to_standby,
   // Command decoder
   input  wire logic        clear_auxiliary_results_cmd,
   input  wire logic        flag_clear_cmd,
   input  wire logic        clear_sel_analog_over,
   input  wire logic        clear_sel_analog_under,
   input  wire logic        clear_sel_digital_over,
   input  wire logic        clear_sel_digital_under,
   input  wire logic        clear_sel_trim,
   input  wire logic        clear_sel_mismatch,
   // Readback
   output logic      [15:0] digital_supply_reading,
   output logic      [15:0] analog_supply_reading,
   output logic      [15:0] resistor_reference_reading,
   output logic      [15:0] converter_mismatch_flags,
   output logic             analog_rail_over_flag,
   output logic             analog_rail_under_flag,
   output logic             digital_rail_over_flag,
   output logic             digital_rail_under_flag,
   output logic             converter_trim_error_flag,
   output logic      [15:0] undervoltage_threshold_code,
   output logic      [15:0] overvoltage_threshold_code
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic        ack_r;
   logic        wr_go;
   logic        rd_cap;
   logic [31:0] cmd_bits;
   logic        sw_aux_clr;
   logic        sw_flag_clr;
   logic [5:0]  sw_sel;
   logic        aux_go;
   logic [5:0]  hw_sel;
   logic [5:0]  clr_sel;
   logic [4:0]  flag_set;
   logic [4:0]  flag_q;
   logic [3:0]  irq_set;
   logic [3:0]  irq_clr;
   logic [3:0]  irq_st;
   logic [3:0]  irq_mask_r;
   logic        irq_r;
   logic [11:0] uv_thr_r;
   logic [11:0] ov_thr_r;
   logic [31:0] thr_word;
   logic [31:0] thr_new;
   logic [31:0] mask_new;
   logic [31:0] rdata_nxt;
   logic [2:0]  rd_load;
   logic [15:0] rd_data [3];
   logic [15:0] rd_q    [3];

   // Keep the old bytes where the byte enable is low
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      be_merge = r;
   endfunction : be_merge

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // One wait state; readdata is caught on the first edge of a read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_go           = avs_write & ack_r;
   assign rd_cap          = avs_read & ~ack_r;

   // ----------------------------------------------------------------
   // Software commands
   // ----------------------------------------------------------------
   assign cmd_bits    = wr_go && (avs_address == ssf_pkg::OFS_CMD)
                        ? be_merge(32'h0000_0000, avs_writedata, avs_byteenable)
                        : 32'h0000_0000;
   assign sw_aux_clr  = cmd_bits[ssf_pkg::CMD_CLR_AUX];
   assign sw_flag_clr = cmd_bits[ssf_pkg::CMD_FLAG_CLR];
   assign sw_sel      = cmd_bits[ssf_pkg::CMD_SEL_LSB +: ssf_pkg::NSEL];

   assign aux_go = clear_auxiliary_results_cmd | sw_aux_clr;
   assign hw_sel = {clear_sel_mismatch, clear_sel_trim, clear_sel_digital_under,
                    clear_sel_digital_over, clear_sel_analog_under,
                    clear_sel_analog_over};
   // Only selected flags are touched by a clear command
   assign clr_sel = ({6{flag_clear_cmd}} & hw_sel) | ({6{sw_flag_clr}} & sw_sel);

   // ----------------------------------------------------------------
   // Supply readings
   // ----------------------------------------------------------------
   assign rd_load = {rref_load, asup_load, dsup_load};
   assign rd_data[0] = dsup_data;
   assign rd_data[1] = asup_data;
   assign rd_data[2] = rref_data;

   // Same reset, sleep and clear codes for all three readings
   for (genvar g = 0; g < 3; g++) begin : g_rd
      ssf_reading u_rd (
         .ref_clk     (ref_clk),
         .resetn      (resetn),
         .load        (rd_load[g]),
         .data        (rd_data[g]),
         .sleep_enter (sleep_enter),
         .clear_aux   (aux_go),
         .q           (rd_q[g])
      );
   end

   assign digital_supply_reading     = rd_q[0];
   assign analog_supply_reading      = rd_q[1];
   assign resistor_reference_reading = rd_q[2];

   // ----------------------------------------------------------------
   // Fault flags
   // ----------------------------------------------------------------
   // Regulator-derived rails dip on wake, so undervoltage is flagged
   assign flag_set = {trim_err_evt,
                      digital_under_evt | sleep_to_standby,
                      digital_over_evt,
                      analog_under_evt | sleep_to_standby,
                      analog_over_evt};

   // All flags reset to 1 and clear only by selector
   ssf_sticky #(.W(ssf_pkg::NFLAG), .RST(ssf_pkg::FLAG_RESET)) u_flags (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .set     (flag_set),
      .clr     (clr_sel[ssf_pkg::NFLAG-1:0]),
      .q       (flag_q)
   );

   // Trim flag shows whether a reset or an error has been seen since the last clear
   assign analog_rail_over_flag     = flag_q[ssf_pkg::F_AOV];
   assign analog_rail_under_flag    = flag_q[ssf_pkg::F_AUV];
   assign digital_rail_over_flag    = flag_q[ssf_pkg::F_DOV];
   assign digital_rail_under_flag   = flag_q[ssf_pkg::F_DUV];
   assign converter_trim_error_flag = flag_q[ssf_pkg::F_TRIM];

   // One bit per channel, all set after reset
   ssf_sticky #(.W(16), .RST(ssf_pkg::MISMATCH_RESET)) u_mism (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .set     (mismatch_evt),
      .clr     ({16{clr_sel[ssf_pkg::SEL_MISM]}}),
      .q       (converter_mismatch_flags)
   );

   // ----------------------------------------------------------------
   // Thresholds
   // ----------------------------------------------------------------
   assign thr_word = {4'h0, ov_thr_r, 4'h0, uv_thr_r};
   assign thr_new  = be_merge(thr_word, avs_writedata, avs_byteenable);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         uv_thr_r <= ssf_pkg::UV_RESET;
         ov_thr_r <= ssf_pkg::OV_RESET;
      end else if (wr_go && (avs_address == ssf_pkg::OFS_THR)) begin
         uv_thr_r <= thr_new[ssf_pkg::THR_UV_LSB +: ssf_pkg::THR_W];
         ov_thr_r <= thr_new[ssf_pkg::THR_OV_LSB +: ssf_pkg::THR_W];
      end
   end

   // Twelve-bit code scaled by 16 onto the result scale
   assign undervoltage_threshold_code = ssf_pkg::thr_to_code(uv_thr_r);
   assign overvoltage_threshold_code  = ssf_pkg::thr_to_code(ov_thr_r);

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign irq_set = {aux_go,
                     trim_err_evt,
                     analog_over_evt | analog_under_evt | digital_over_evt
                     | digital_under_evt | sleep_to_standby,
                     |mismatch_evt};
   // Cleared at capture so no event slips between capture and release
   assign irq_clr = {4{rd_cap && (avs_address == ssf_pkg::OFS_IRQ_ST)}};

   ssf_sticky #(.W(ssf_pkg::NIRQ), .RST(ssf_pkg::IRQ_ST_RESET)) u_irq (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .set     (irq_set),
      .clr     (irq_clr),
      .q       (irq_st)
   );

   assign mask_new = be_merge({28'h0000000, irq_mask_r}, avs_writedata, avs_byteenable);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_mask_r <= ssf_pkg::IRQ_MASK_RESET;
      end else if (wr_go && (avs_address == ssf_pkg::OFS_IRQ_MASK)) begin
         irq_mask_r <= mask_new[ssf_pkg::NIRQ-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_st & irq_mask_r);
      end
   end

   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Codes sit in the low half, upper bits read zero, except the threshold word, which has the overvoltage code in bits 27:16
   always_comb begin
      unique case (avs_address)
         ssf_pkg::OFS_DSUP:     rdata_nxt = {16'h0000, rd_q[0]};
         ssf_pkg::OFS_ASUP:     rdata_nxt = {16'h0000, rd_q[1]};
         ssf_pkg::OFS_RREF:     rdata_nxt = {16'h0000, rd_q[2]};
         ssf_pkg::OFS_MISMATCH: rdata_nxt = {16'h0000, converter_mismatch_flags};
         ssf_pkg::OFS_FLAGS:    rdata_nxt = {27'h0000000, flag_q};
         ssf_pkg::OFS_THR:      rdata_nxt = thr_word;
         ssf_pkg::OFS_IRQ_ST:   rdata_nxt = {28'h0000000, irq_st};
         ssf_pkg::OFS_IRQ_MASK: rdata_nxt = {28'h0000000, irq_mask_r};
         default:               rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_cap) begin
         avs_readdata <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_dsup_clear;
      aux_go && !sleep_enter |=> digital_supply_reading == 16'h8000;
   endproperty
   a_dsup_clear: assert property (p_dsup_clear) else $error("aux clear missed");

   property p_asup_sleep;
      sleep_enter |=> analog_supply_reading == 16'h7FFF;
   endproperty
   a_asup_sleep: assert property (p_asup_sleep) else $error("sleep value wrong");

   property p_rref_load;
      rref_load && !sleep_enter && !aux_go |=> resistor_reference_reading == $past(rref_data);
   endproperty
   a_rref_load: assert property (p_rref_load) else $error("reading not loaded");

   property p_read_fmt;
      rd_cap && avs_address == ssf_pkg::OFS_DSUP
         |=> avs_readdata == {16'h0000, $past(digital_supply_reading)};
   endproperty
   a_read_fmt: assert property (p_read_fmt) else $error("reading readback wrong");

   property p_thr_code;
      wr_go && avs_address == ssf_pkg::OFS_THR && avs_byteenable == 4'hF
         |=> overvoltage_threshold_code == {$past(avs_writedata[27:16]), 4'h0};
   endproperty
   a_thr_code: assert property (p_thr_code) else $error("threshold code wrong");

   property p_mism_set;
      mismatch_evt != 16'h0000
         |=> (converter_mismatch_flags & $past(mismatch_evt)) == $past(mismatch_evt);
   endproperty
   a_mism_set: assert property (p_mism_set) else $error("mismatch not flagged");

   property p_aov_clear;
      clr_sel[0] && !analog_over_evt ##1 !analog_over_evt[*2] |-> !analog_rail_over_flag;
   endproperty
   a_aov_clear: assert property (p_aov_clear) else $error("aov not cleared");

   property p_auv_set;
      analog_under_evt |=> analog_rail_under_flag;
   endproperty
   a_auv_set: assert property (p_auv_set) else $error("auv not set");

   property p_auv_wake;
      sleep_to_standby |=> analog_rail_under_flag && digital_rail_under_flag;
   endproperty
   a_auv_wake: assert property (p_auv_wake) else $error("wake uv not set");

   property p_dov_set;
      digital_over_evt ##1 !clr_sel[ssf_pkg::F_DOV] |=> digital_rail_over_flag;
   endproperty
   a_dov_set: assert property (p_dov_set) else $error("dov lost");

   property p_duv_clear;
      flag_clear_cmd && clear_sel_digital_under && !digital_under_evt && !sleep_to_standby
         |=> !digital_rail_under_flag;
   endproperty
   a_duv_clear: assert property (p_duv_clear) else $error("duv not cleared");

   property p_duv_wake;
      $rose(sleep_to_standby) |=> digital_rail_under_flag;
   endproperty
   a_duv_wake: assert property (p_duv_wake) else $error("wake duv not set");

   property p_trim_set;
      trim_err_evt |=> converter_trim_error_flag;
   endproperty
   a_trim_set: assert property (p_trim_set) else $error("trim flag not set");

   property p_keep;
      !clr_sel[2] && digital_rail_over_flag |=> digital_rail_over_flag;
   endproperty
   a_keep: assert property (p_keep) else $error("unselected flag lost");

   c_aux: cover property (aux_go ##1 digital_supply_reading == 16'h8000);
   c_wake: cover property (sleep_to_standby ##1 irq_st[ssf_pkg::IRQ_RAIL]);
   c_clr: cover property (flag_clear_cmd && clear_sel_analog_over ##1 !analog_rail_over_flag);
   c_irq: cover property ($rose(irq));

endmodule : ssf_status

/* File: dv/ssf_host.sv */
/* Host controller model: Avalon-MM master for the status block.
   Assumes the slave stalls with waitrequest; the bench bounds every wait. */
`timescale 1ns/10ps
module ssf_host (
   // Clock
   input  wire logic        ref_clk,
   // Avalon-MM master
   output logic      [5:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   initial begin
      avs_address    = '0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = '0;
      avs_byteenable = 4'hF;
   end

   // Request held until waitrequest is seen low at a rising edge
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge ref_clk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer
endmodule : ssf_host

/* File: dv/ssf_status_tb.sv */
/* Self-checking bench for the supply status block.
   Assumes the package register map and pulse-style event and command pins. */
`timescale 1ns/10ps
module ssf_status_tb;
   logic        ref_clk, resetn, avs_read, avs_write, avs_waitrequest, irq;
   logic [5:0]  avs_address, sel;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable;
   logic [15:0] d, mm, rd_d, rd_a, rd_r, uvc, ovc, mmo;
   logic [8:0]  p;
   logic [2:0]  ld;
   logic [4:0]  fl, fo;
   int          failures, compares, cyc;

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   ssf_status i_ssf_status (
      .ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
      .dsup_load(ld[0]), .dsup_data(d), .asup_load(ld[1]), .asup_data(d),
      .rref_load(ld[2]), .rref_data(d), .mismatch_evt(mm),
      .analog_over_evt(p[0]), .analog_under_evt(p[1]), .digital_over_evt(p[2]),
      .digital_under_evt(p[3]), .trim_err_evt(p[4]), .sleep_enter(p[5]),
      .sleep_to_standby(p[6]), .clear_auxiliary_results_cmd(p[7]), .flag_clear_cmd(p[8]),
      .clear_sel_analog_over(sel[0]), .clear_sel_analog_under(sel[1]),
      .clear_sel_digital_over(sel[2]), .clear_sel_digital_under(sel[3]),
      .clear_sel_trim(sel[4]), .clear_sel_mismatch(sel[5]),
      .digital_supply_reading(rd_d), .analog_supply_reading(rd_a),
      .resistor_reference_reading(rd_r), .converter_mismatch_flags(mmo),
      .analog_rail_over_flag(fo[0]), .analog_rail_under_flag(fo[1]),
      .digital_rail_over_flag(fo[2]), .digital_rail_under_flag(fo[3]),
      .converter_trim_error_flag(fo[4]),
      .undervoltage_threshold_code(uvc), .overvoltage_threshold_code(ovc));

   ssf_host i_ssf_host (.ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      i_ssf_host.xfer(1'b0, a, '0, q);
      chk(q, exp);
   endtask : rd

   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      i_ssf_host.xfer(1'b1, a, v, q);
   endtask : wr

   // One-cycle pulse on pins; data is left standing afterwards
   task automatic pulse(input logic [8:0] v, input logic [5:0] s,
                        input logic [2:0] m = '0, input logic [15:0] dv = '0,
                        input logic [15:0] mv = '0);
      @(posedge ref_clk);
      p   <= v;
      sel <= s;
      ld  <= m;
      d   <= dv;
      mm  <= mv;
      @(posedge ref_clk);
      p   <= '0;
      sel <= '0;
      ld  <= '0;
      mm  <= '0;
   endtask : pulse

   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   // Hang guard: the sequence needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      p = '0;
      sel = '0;
      ld = '0;
      d = '0;
      mm = '0;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(6'h00, 32'h7FFF);
      rd(6'h04, 32'h7FFF);
      rd(6'h08, 32'h7FFF);
      rd(6'h0C, 32'hFFFF);
      rd(6'h10, 32'h1F);
      rd(6'h18, 32'h07FF_0800);
      rd(6'h3C, 32'h0);
      $display("test reset done");
      fl = 5'h1F;
      for (int i = 0; i < 5; i++) begin
         wr(6'h14, 32'h2 | (32'h100 << i));
         fl[i] = 1'b0;
         rd(6'h10, {27'h0, fl});
      end
      for (int i = 0; i < 5; i++) begin
         pulse(9'h1 << i, '0);
         fl[i] = 1'b1;
         rd(6'h10, {27'h0, fl});
      end
      pulse(9'h100, 6'h1F);
      rd(6'h10, 32'h0);
      pulse(9'h040, '0);
      rd(6'h10, 32'hA);
      $display("test flags done");
      pulse(9'h100, 6'h20);
      rd(6'h0C, 32'h0);
      pulse('0, '0, '0, '0, 16'h8001);
      rd(6'h0C, 32'h8001);
      rd(6'h10, 32'hA);
      chk({mmo, 11'h000, fo}, 32'h8001_000A);
      $display("test mismatch done");
      pulse('0, '0, 3'h1, 16'h8000);
      pulse('0, '0, 3'h2, 16'h7FFE);
      pulse('0, '0, 3'h4, 16'h1234);
      rd(6'h00, 32'h8000);
      rd(6'h04, 32'h7FFE);
      rd(6'h08, 32'h1234);
      wr(6'h00, 32'h5555);
      rd(6'h00, 32'h8000);
      wr(6'h14, 32'h1);
      for (int i = 0; i < 3; i++) rd(6'(4 * i), 32'h8000);
      pulse(9'h020, '0);
      @(negedge ref_clk);
      chk({rd_d, rd_a}, 32'h7FFF_7FFF);
      chk(rd_r, 16'h7FFF);
      $display("test readings done");
      wr(6'h18, 32'h0800_07FF);
      rd(6'h18, 32'h0800_07FF);
      chk({uvc, ovc}, 32'h7FF0_8000);
      $display("test thresholds done");
      wr(6'h20, 32'h2);
      rd(6'h20, 32'h2);
      rd(6'h1C, 32'hF);
      repeat (2) @(posedge ref_clk);
      chk(irq, 32'h0);
      pulse(9'h001, '0);
      repeat (2) @(posedge ref_clk);
      chk(irq, 32'h1);
      pulse(9'h080, '0);
      rd(6'h1C, 32'hA);
      repeat (2) @(posedge ref_clk);
      chk(irq, 32'h0);
      $display("test irq done");
      summarize();
   end
endmodule : ssf_status_tb
